// ### hdl/sat16_timer.sv
// Wishbone-attached 16-bit timer with aliases, prescaler, period match and interrupt
`include "sat16_consts.svh"

module sat16_timer
  import sat16_pkg::*;
#(
  parameter int CW = 16,                       // Counter width
  parameter logic [15:0] PRE_DIV0 = 16'h0001,  // Prescaler ratios per code
  parameter logic [15:0] PRE_DIV1 = 16'h0008,
  parameter logic [15:0] PRE_DIV2 = 16'h0040,
  parameter logic [15:0] PRE_DIV3 = 16'h0100
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Timer pins
  input  wire logic        timerExternalClockPin,
  input  wire logic        gateIn,
  // Interrupt
  output logic             irq
);
  logic [31:0]   timerControl;
  logic [CW-1:0] count;
  logic [CW-1:0] period;
  logic [`SAT16_ST_WIDTH-1:0] status;
  logic [`SAT16_ST_WIDTH-1:0] mask;
  logic [15:0]   preCount;
  logic [15:0]   preRatio;
  sat16_mode_e   mode;
  logic          srcTick;
  logic          countTick;
  logic          matchEv;
  logic          wrapEv;
  logic          wbReq;
  logic          wbWrite;
  logic [31:0]   selMask;
  logic [31:0]   wdat;
  logic [31:0]   next_ctrl;

  sat16_tick_if tick ();

  // Byte-lane mask from sel
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      selMask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // Writes land on the edge at which the master samples ack,
  // while it still holds address and data; reads are answered one cycle earlier
  assign wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign wdat    = wb_dat_i & selMask;

  // Acknowledge one cycle after the request, dropped the following cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  // Control next value: plain, clear, set and toggle aliases
  always_comb begin
    next_ctrl = timerControl;
    if (wbWrite) begin
      unique case (wb_adr_i)
        `SAT16_OFF_CTRL:     next_ctrl = (timerControl & ~selMask) | wdat;
        `SAT16_OFF_CTRL_CLR: next_ctrl = timerControl & ~wdat;
        `SAT16_OFF_CTRL_SET: next_ctrl = timerControl | wdat;
        `SAT16_OFF_CTRL_INV: next_ctrl = timerControl ^ wdat;
        default:             next_ctrl = timerControl;
      endcase
    end
    next_ctrl = next_ctrl & `SAT16_CTRL_WMASK;
  end

  // Control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timerControl <= `SAT16_CTRL_RESET;
    end else begin
      timerControl <= next_ctrl;
    end
  end

  // Period register; low half only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period <= CW'(`SAT16_PERIOD_RESET);
    end else if (wbWrite && wb_adr_i == `SAT16_OFF_PERIOD) begin
      period <= (period & ~CW'(selMask)) | CW'(wdat);
    end
  end

  // Mode decode; sync select only matters for the external source
  always_comb begin
    if (timerControl[`SAT16_BIT_SRC]) begin
      mode = timerControl[`SAT16_BIT_SYNC] ? SAT16_EXT_SYNC : SAT16_EXT_ASYNC;
    end else begin
      mode = timerControl[`SAT16_BIT_GATE] ? SAT16_INT_GATED : SAT16_INT;
    end
  end

  assign tick.extSync  = (mode == SAT16_EXT_SYNC);
  assign tick.extAsync = (mode == SAT16_EXT_ASYNC);

  sat16_edge_front u_front (
    .clk    (clk),
    .rst_n  (rst_n),
    .extPin (timerExternalClockPin),
    .tick   (tick.front)
  );

  // Source tick per mode
  always_comb begin
    unique case (mode)
      SAT16_INT:       srcTick = 1'b1;
      SAT16_INT_GATED: srcTick = gateIn;  // Counts while gate is high
      SAT16_EXT_SYNC:  srcTick = tick.extTick;
      SAT16_EXT_ASYNC: srcTick = tick.extTick;
    endcase
  end

  // Ratio lookup from the two-bit prescale field
  always_comb begin
    unique case (timerControl[`SAT16_PRE_HI:`SAT16_PRE_LO])
      2'h0: preRatio = PRE_DIV0;
      2'h1: preRatio = PRE_DIV1;
      2'h2: preRatio = PRE_DIV2;
      2'h3: preRatio = PRE_DIV3;
    endcase
  end

  // Prescaler; restarts when the timer is off
  always_ff @(posedge clk) begin
    if (!rst_n || !timerControl[`SAT16_BIT_ON]) begin
      preCount <= 16'h0000;
    end else if (srcTick) begin
      preCount <= (preCount + 16'h0001 >= preRatio) ? 16'h0000 : preCount + 16'h0001;
    end
  end

  assign countTick = timerControl[`SAT16_BIT_ON] & srcTick
                   & (preCount + 16'h0001 >= preRatio);

  // No idle or sleep input: the counter never stops for them
  assign matchEv = countTick & (count == period);
  assign wrapEv  = countTick & (count == {CW{1'b1}}) & (count != period);

  // Counter; software write has priority below the match reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (matchEv) begin
      count <= '0;
    end else if (wbWrite && wb_adr_i == `SAT16_OFF_COUNT) begin
      count <= (count & ~CW'(selMask)) | CW'(wdat);
    end else if (countTick) begin
      count <= count + CW'(1);
    end
  end

  // Sticky status; set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      for (int b = 0; b < `SAT16_ST_WIDTH; b++) begin
        if ((b == `SAT16_ST_MATCH && matchEv) || (b == `SAT16_ST_WRAP && wrapEv)) begin
          status[b] <= 1'b1;
        end else if (wbWrite && wb_adr_i == `SAT16_OFF_STATUS && wdat[b]) begin
          status[b] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (wbWrite && wb_adr_i == `SAT16_OFF_MASK) begin
      mask <= wdat[`SAT16_ST_WIDTH-1:0];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Read data, registered; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (wbReq && !wb_we_i) begin
      unique case (wb_adr_i)
        `SAT16_OFF_CTRL, `SAT16_OFF_CTRL_CLR,
        `SAT16_OFF_CTRL_SET, `SAT16_OFF_CTRL_INV: wb_dat_o <= timerControl;
        `SAT16_OFF_COUNT:  wb_dat_o <= 32'(count);
        `SAT16_OFF_PERIOD: wb_dat_o <= 32'(period);
        `SAT16_OFF_STATUS: wb_dat_o <= 32'(status);
        `SAT16_OFF_MASK:   wb_dat_o <= 32'(mask);
        default:           wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule

// ### inc/sat16_consts.svh
// Register map, field positions, reset values and status bits of the 16-bit timer
// Contract
// - One timer, 16-bit counter, sync or async
// - Interval timer and external event counter
// - Four modes: int, gated, ext sync, ext async
// - Source select: one external pin, zero internal
// - Sync select routes external clock through synchroniser
// - Sync select ignored for internal source
// - Control bits 3 and 0 read zero
// - Keeps counting in Idle and Sleep
// - Async external counts low-power secondary oscillator
// - Clear, set, toggle aliases affect one-bits only
`ifndef SAT16_CONSTS_SVH
`define SAT16_CONSTS_SVH

// Word offsets (byte addresses)
`define SAT16_OFF_CTRL      8'h00
`define SAT16_OFF_CTRL_CLR  8'h04
`define SAT16_OFF_CTRL_SET  8'h08
`define SAT16_OFF_CTRL_INV  8'h0c
`define SAT16_OFF_COUNT     8'h10
`define SAT16_OFF_PERIOD    8'h20
`define SAT16_OFF_STATUS    8'h30
`define SAT16_OFF_MASK      8'h40

// Control field positions
`define SAT16_BIT_SRC       1
`define SAT16_BIT_SYNC      2
`define SAT16_BIT_GATE      7
`define SAT16_BIT_ON        15
`define SAT16_PRE_LO        4
`define SAT16_PRE_HI        5
`define SAT16_BIT_STOPIDLE  13

// Writable control bits; bits 3 and 0 are left out
`define SAT16_CTRL_WMASK    32'h0000a0f6
`define SAT16_CTRL_RESET    32'h00000000
`define SAT16_PERIOD_RESET  16'hffff

// Status bits
`define SAT16_ST_MATCH      0
`define SAT16_ST_WRAP       1
`define SAT16_ST_WIDTH      2

`endif

// ### inc/sat16_pkg.sv
// Types used by the 16-bit timer core module
package sat16_pkg;
  typedef enum logic [1:0] {
    SAT16_INT,
    SAT16_INT_GATED,
    SAT16_EXT_SYNC,
    SAT16_EXT_ASYNC
  } sat16_mode_e;
endpackage

// ### inc/sat16_tick_if.sv
// Tick request and answer between the timer core and its edge front end
interface sat16_tick_if;
  logic extSync;
  logic extAsync;
  logic extTick;
  modport core (output extSync, output extAsync, input extTick);
  modport front (input extSync, input extAsync, output extTick);
endinterface

// ### hdl/sat16_edge_front.sv
// External clock pin front end: synchronised or direct rising edge detect
module sat16_edge_front (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // External pin
  input  wire logic   extPin,
  // Core side
  sat16_tick_if.front tick
);
  logic syncA;
  logic syncB;
  logic syncPrev;
  logic rawPrev;

  // Two-stage synchroniser; first stage only feeds the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncPrev <= 1'b0;
    end else begin
      syncA <= extPin;
      syncB <= syncA;
      syncPrev <= syncB;
    end
  end

  // Unsynchronised path samples the pin once, lower latency, no metastability guard
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rawPrev <= 1'b0;
    end else begin
      rawPrev <= extPin;
    end
  end

  // Edge chosen by path
  assign tick.extTick = tick.extSync ? (syncB & ~syncPrev)
                      : tick.extAsync ? (extPin & ~rawPrev) : 1'b0;
endmodule

// ### tb/sat16_timer_sva.sv
// Bus handshake and register read-back checks on the 16-bit timer ports
module sat16_timer_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rdAck;
  // Read completion; the master still holds the address here
  assign rdAck = wb_ack_o && !wb_we_i;
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_ctrl_gap_bits: assert property (
    rdAck && wb_adr_i[7:4] == 4'h0 |-> wb_dat_o[3] == 1'b0 && wb_dat_o[0] == 1'b0)
    else $error("gap bit set");
  a_ctrl_unused_zero: assert property (
    rdAck && wb_adr_i[7:4] == 4'h0 |-> (wb_dat_o & ~32'h0000a0f6) == 32'h0)
    else $error("unused bit set");
  a_count_width: assert property (
    rdAck && wb_adr_i == 8'h10 |-> wb_dat_o[31:16] == 16'h0)
    else $error("count wider");
  a_status_width: assert property (
    rdAck && wb_adr_i == 8'h30 |-> wb_dat_o[31:2] == 30'h0)
    else $error("status wider");
  a_unmapped_zero: assert property (rdAck && wb_adr_i > 8'h40 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind sat16_timer sat16_timer_sva sat16_timer_sva_inst (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ### tb/test_sync_async_16bit_timer.sv
// Self-checking bench for the 16-bit timer
module test_sync_async_16bit_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, pin = 0, gate = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf, selReq = 4'hf;
  logic [31:0] dat = 32'h0, dOut, q;
  logic        ack, irq;
  int          bad_count = 0, total_checks = 0;
  sat16_timer sat16_timer_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dOut),
    .wb_ack_o(ack), .timerExternalClockPin(pin), .gateIn(gate), .irq(irq));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask
  // One classic cycle; request held until ack is sampled
  // Idle edge first keeps accesses off the cycle after a switch-off
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= selReq;
    do @(posedge clk); while (ack !== 1'b1);
    q = dOut;
    cyc <= 0; stb <= 0;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) pin <= 1;
      repeat (2) @(posedge clk);
      pin <= 0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic s_reset;
    wb(0, 8'h00, 0); chk(q, 32'h0);
    wb(0, 8'h10, 0); chk(q, 32'h0);
    wb(0, 8'h20, 0); chk(q, 32'h0000ffff);
    wb(0, 8'h30, 0); chk(q, 32'h0);
    wb(0, 8'h50, 0); chk(q, 32'h0);
  endtask
  // Aliases touch only the one-bits; gap bits never stick
  task automatic s_alias;
    wb(1, 8'h00, 32'hffffffff); wb(0, 8'h00, 0); chk(q, 32'h0000a0f6);
    wb(1, 8'h04, 32'h8000); wb(0, 8'h00, 0); chk(q, 32'h000020f6);
    wb(1, 8'h0c, 32'h0006); wb(0, 8'h0c, 0); chk(q, 32'h000020f0);
    wb(1, 8'h08, 32'h8009); wb(0, 8'h08, 0); chk(q, 32'h0000a0f0);
    wb(1, 8'h00, 0);
  endtask
  // Internal count with sync bit set, which must not matter
  task automatic s_match;
    wb(1, 8'h20, 4); wb(1, 8'h00, 32'h8004);
    for (int i = 0; i < 20; i++) begin
      wb(0, 8'h30, 0);
      if (q[0] === 1'b1) break;
    end
    chk(q, 32'h1);
    wb(1, 8'h00, 0); chk({31'h0, irq}, 0);
    wb(1, 8'h40, 1); repeat (2) @(posedge clk); chk({31'h0, irq}, 1);
    wb(1, 8'h30, 1); wb(0, 8'h30, 0); chk(q, 0);
    repeat (2) @(posedge clk); chk({31'h0, irq}, 0);
    wb(1, 8'h10, 32'hfffe); wb(1, 8'h00, 32'h8000); repeat (10) @(posedge clk);
    wb(1, 8'h00, 0); wb(0, 8'h30, 0); chk(q, 32'h3);
    wb(1, 8'h30, 3);
  endtask
  // Byte enables keep unselected lanes, so the on bit stays clear
  task automatic s_sel;
    selReq = 4'h1; wb(1, 8'h00, 32'hffffffff); selReq = 4'hf;
    wb(0, 8'h00, 0); chk(q, 32'h000000f6);
    wb(1, 8'h00, 0);
  endtask
  // Pin edges counted exactly, direct and synchronised
  task automatic s_ext(input logic [31:0] c, input int n, input logic [31:0] e);
    wb(1, 8'h20, 32'hffff); wb(1, 8'h10, 0); wb(1, 8'h00, c);
    pulse(n); repeat (6) @(posedge clk);
    wb(1, 8'h00, 0); wb(0, 8'h10, 0); chk(q, e);
  endtask
  // Gate low holds the count, gate high lets it run
  task automatic s_gate;
    wb(1, 8'h10, 0); wb(1, 8'h00, 32'h8080);
    repeat (20) @(posedge clk);
    wb(0, 8'h10, 0); chk(q, 0);
    gate <= 1; repeat (10) @(posedge clk);
    wb(0, 8'h10, 0); chk(q, 11);
    wb(1, 8'h00, 0);
  endtask
  task automatic conclude;
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard well beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    s_reset();
    s_alias();
    s_match();
    s_ext(32'h8002, 5, 5);
    s_ext(32'h8006, 5, 5);
    s_ext(32'h8012, 20, 2);
    s_gate();
    s_sel();
    // Mid-run reset while the bus is idle
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    s_reset();
    conclude();
  end
endmodule
